// ==== hdl/can_rx_ovf_defines.vh ====
// Constants for the receive overrun and buffer tail block
`ifndef CAN_RX_OVF_DEFINES_VH
`define CAN_RX_OVF_DEFINES_VH
// Register byte offsets on APB
`define OFS_OVF_LOW 12'h000
`define OFS_OVF_HIGH 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00c
`define OFS_BUF_SEL 12'h010
`define OFS_BUF_WORD6 12'h014
`define OFS_BUF_WORD7 12'h018
// Field positions
`define FILT_LSB 8
`define FILT_MSB 12
// Interrupt status bits
`define IRQ_OVF_BIT 0
`define IRQ_RXSTORE_BIT 1
`define IRQ_WIDTH 2
// Reset values
`define OVF_RESET 16'h0000
`define MASK_RESET 2'h0
`endif

// ==== hdl/ovf_flag_bank.v ====
// Sticky overrun flags, one per buffer, cleared by writing zero
`timescale 1ns/1ps
`default_nettype none
module ovf_flag_bank #(
    parameter NBUF = 32
) (
    input wire clk_sys,
    input wire rst,
    input wire [NBUF-1:0] setVec,
    input wire [NBUF-1:0] clrVec,
    output wire [NBUF-1:0] flags
);
    reg [NBUF-1:0] flags_ff;
    genvar i;
    // One flag per buffer; set beats clear so no overrun is lost
    generate
        for (i = 0; i < NBUF; i = i + 1) begin : gFlag
            always @(posedge clk_sys) begin
                if (rst) begin
                    flags_ff[i] <= 1'b0;
                end else if (setVec[i]) begin
                    flags_ff[i] <= 1'b1;
                end else if (clrVec[i]) begin
                    flags_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate
    assign flags = flags_ff;
endmodule // ovf_flag_bank
`default_nettype wire

// ==== hdl/buf_tail_store.v ====
// Words 6 and 7 of every message buffer, held in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_ovf_defines.vh"
module buf_tail_store #(
    parameter NBUF = 32,
    parameter IW = 5
) (
    input wire clk_sys,
    input wire [IW-1:0] swIdx,
    input wire swWr6,
    input wire swWr7,
    input wire [15:0] swData,
    input wire rxWr,
    input wire [IW-1:0] rxIdx,
    input wire [15:0] rxWord6,
    input wire [4:0] rxFilt,
    output wire [15:0] rdWord6,
    output wire [15:0] rdWord7
);
    reg [15:0] word6Mem [0:NBUF-1];
    reg [4:0] filtMem [0:NBUF-1];
    genvar i;
    // No reset: contents are undefined until written
    generate
        for (i = 0; i < NBUF; i = i + 1) begin : gEnt
            always @(posedge clk_sys) begin
                if (rxWr && rxIdx == i) begin
                    word6Mem[i] <= rxWord6;
                    filtMem[i] <= rxFilt;
                end else begin
                    if (swWr6 && swIdx == i) begin
                        word6Mem[i] <= swData;
                    end
                    if (swWr7 && swIdx == i) begin
                        filtMem[i] <= swData[`FILT_MSB:`FILT_LSB];
                    end
                end
            end
        end
    endgenerate
    // Byte 7 high, byte 6 low; filter code in 12:8, rest zero
    assign rdWord6 = word6Mem[swIdx];
    assign rdWord7 = {3'h0, filtMem[swIdx], 8'h00};
endmodule // buf_tail_store
`default_nettype wire

// ==== hdl/can_rx_overflow_and_buffer_tail.v ====
// APB top: receive overrun flags and message buffer tail words
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_ovf_defines.vh"
// Function
// - Store attempt into a full buffer sets that buffer's overrun flag.
// - Writing 0 clears an overrun flag; writing 1 does nothing.
// - Flag 0 means no overrun; a set flag holds until cleared.
// - Two 16-bit registers: buffers 0-15 low, 16-31 high.
// - Word 6 holds byte 7 high, byte 6 low, read and write.
// - Word 7 bits 12:8 hold matching filter index, others read zero.
// - Filter index written only when storing a received message; here a software write to word 7 also sets it.
module can_rx_overflow_and_buffer_tail #(
    parameter NBUF = 32,
    parameter IW = 5
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rxStore,
    input wire [IW-1:0] rxBufIdx,
    input wire rxBufFull,
    input wire [15:0] rxPayload67,
    input wire [4:0] matchingFilterIndex,
    output reg irq
);
    reg [IW-1:0] bufSel_ff;
    reg [`IRQ_WIDTH-1:0] irqStatus_ff;
    reg [`IRQ_WIDTH-1:0] irqMask_ff;
    reg [`IRQ_WIDTH-1:0] nxt_irqStatus;
    reg [NBUF-1:0] ovfSet;
    reg [NBUF-1:0] ovfClr;
    reg [31:0] nxt_prdata;
    reg nxt_slverr;
    reg decHit;
    wire [NBUF-1:0] rxBufferOverrunFlag;
    wire [15:0] rdWord6;
    wire [15:0] rdWord7;
    wire acc;
    wire wrAcc;
    wire storeOk;

    // Access phase takes two cycles (one wait state); pready rises once per access
    assign acc = psel && penable && !pready;
    assign wrAcc = acc && pwrite;
    assign storeOk = rxStore && !rxBufFull;

    // Overrun set from rx path, clear from zero bits of a flag write
    always @* begin
        ovfSet = {NBUF{1'b0}};
        ovfClr = {NBUF{1'b0}};
        if (rxStore && rxBufFull) begin
            ovfSet[rxBufIdx] = 1'b1;
        end
        if (wrAcc && paddr == `OFS_OVF_LOW) begin
            ovfClr[15:0] = ~pwdata[15:0];
        end
        if (wrAcc && paddr == `OFS_OVF_HIGH) begin
            ovfClr[31:16] = ~pwdata[15:0];
        end
    end

    ovf_flag_bank #(
        .NBUF(NBUF)
    ) uFlags (
        .clk_sys(clk_sys),
        .rst(rst),
        .setVec(ovfSet),
        .clrVec(ovfClr),
        .flags(rxBufferOverrunFlag)
    );

    // Rx store wins the buffer slot over a software write that cycle
    buf_tail_store #(
        .NBUF(NBUF),
        .IW(IW)
    ) uTail (
        .clk_sys(clk_sys),
        .swIdx(bufSel_ff),
        .swWr6(wrAcc && paddr == `OFS_BUF_WORD6),
        .swWr7(wrAcc && paddr == `OFS_BUF_WORD7),
        .swData(pwdata[15:0]),
        .rxWr(storeOk),
        .rxIdx(rxBufIdx),
        .rxWord6(rxPayload67),
        .rxFilt(matchingFilterIndex),
        .rdWord6(rdWord6),
        .rdWord7(rdWord7)
    );

    // Interrupt status: events set, write-one clears, set wins
    always @* begin
        nxt_irqStatus = irqStatus_ff;
        if (wrAcc && paddr == `OFS_IRQ_STATUS) begin
            nxt_irqStatus = irqStatus_ff & ~pwdata[`IRQ_WIDTH-1:0];
        end
        if (rxStore && rxBufFull) begin
            nxt_irqStatus[`IRQ_OVF_BIT] = 1'b1;
        end
        if (storeOk) begin
            nxt_irqStatus[`IRQ_RXSTORE_BIT] = 1'b1;
        end
    end

    // Read mux and unmapped-address decode
    always @* begin
        nxt_prdata = 32'h0000_0000;
        decHit = 1'b1;
        case (paddr)
            `OFS_OVF_LOW: nxt_prdata[15:0] = rxBufferOverrunFlag[15:0];
            `OFS_OVF_HIGH: nxt_prdata[15:0] = rxBufferOverrunFlag[31:16];
            `OFS_IRQ_STATUS: nxt_prdata[`IRQ_WIDTH-1:0] = irqStatus_ff;
            `OFS_IRQ_MASK: nxt_prdata[`IRQ_WIDTH-1:0] = irqMask_ff;
            `OFS_BUF_SEL: nxt_prdata[IW-1:0] = bufSel_ff;
            `OFS_BUF_WORD6: nxt_prdata[15:0] = rdWord6;
            `OFS_BUF_WORD7: nxt_prdata[15:0] = rdWord7;
            default: decHit = 1'b0;
        endcase
        nxt_slverr = acc && !decHit;
        if (!acc || pwrite) begin
            nxt_prdata = 32'h0000_0000;
        end
    end

    // Bus outputs and control registers
    always @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            bufSel_ff <= {IW{1'b0}};
            irqStatus_ff <= `MASK_RESET;
            irqMask_ff <= `MASK_RESET;
            irq <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= nxt_slverr;
            prdata <= nxt_prdata;
            irqStatus_ff <= nxt_irqStatus;
            if (wrAcc && paddr == `OFS_BUF_SEL) begin
                bufSel_ff <= pwdata[IW-1:0];
            end
            if (wrAcc && paddr == `OFS_IRQ_MASK) begin
                irqMask_ff <= pwdata[`IRQ_WIDTH-1:0];
            end
            // Level irq, registered from next status so it changes on the same edge as status
            irq <= |(nxt_irqStatus & irqMask_ff);
        end
    end
endmodule // can_rx_overflow_and_buffer_tail
`default_nettype wire

// ==== testbench/can_rx_ovf_asserts.sv ====
// Port checker for the receive overrun and buffer tail block
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_ovf_defines.vh"
module can_rx_ovf_asserts #(
    parameter IW = 5
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxStore,
    input wire logic [IW-1:0] rxBufIdx,
    input wire logic rxBufFull,
    input wire logic irq
);
    logic [31:0] ovf_ff, nxt_ovf, clr, expRd_ff;
    wire taken = psel & penable & ~pready;
    wire isLow = paddr == `OFS_OVF_LOW;
    wire isFlag = isLow | (paddr == `OFS_OVF_HIGH);
    // Shadow flags; set after clear so a coincident overrun survives
    always_comb begin
        clr = 32'h0;
        if (taken & pwrite & isFlag)
            clr = isLow ? {16'h0, ~pwdata[15:0]} : {~pwdata[15:0], 16'h0};
        nxt_ovf = (ovf_ff & ~clr) | ({31'h0, rxStore & rxBufFull} << rxBufIdx);
    end
    // Read data is the flag value before the accepting edge
    always_ff @(posedge clk_sys) begin
        ovf_ff <= rst ? 32'h0 : nxt_ovf;
        if (taken)
            expRd_ff <= {16'h0, isLow ? ovf_ff[15:0] : ovf_ff[31:16]};
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_flagRead; pready && !pwrite && isFlag |-> prdata == expRd_ff; endproperty
    a_flagRead: assert property (p_flagRead) else $error("flag read");
    property p_word6Up; pready && !pwrite && paddr == `OFS_BUF_WORD6 |-> prdata[31:16] == 16'h0; endproperty
    a_word6Up: assert property (p_word6Up) else $error("word6 upper bits");
    property p_word7Zero; pready && !pwrite && paddr == `OFS_BUF_WORD7 |-> prdata[31:13] == 19'h0 && prdata[7:0] == 8'h0; endproperty
    a_word7Zero: assert property (p_word7Zero) else $error("word7 spare bits");
    property p_readyPulse; pready |=> !pready; endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("ready too long");
    property p_answer; taken |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_refuse; pslverr |-> pready && prdata == 32'h0; endproperty
    a_refuse: assert property (p_refuse) else $error("bad refusal");
    property p_idleQuiet; !psel [*2] |=> !pready && !pslverr; endproperty
    a_idleQuiet: assert property (p_idleQuiet) else $error("answer when idle");
    property p_rstQuiet; disable iff (1'b0) rst |=> !pready && !irq; endproperty
    a_rstQuiet: assert property (p_rstQuiet) else $error("outputs in reset");
    c_overrun: cover property (rxStore && rxBufFull);
    c_refused: cover property (pslverr);
    c_irq: cover property (irq);
endmodule // can_rx_ovf_asserts
bind can_rx_overflow_and_buffer_tail can_rx_ovf_asserts #(.IW(IW)) u_chk (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxStore, .rxBufIdx, .rxBufFull, .irq);
`default_nettype wire

// ==== testbench/rx_path_model.sv ====
// Receive path stand-in that stores messages into buffers
`timescale 1ns/1ps
`default_nettype none
module rx_path_model (
    input wire logic clk_sys,
    output logic rxStore,
    output logic [4:0] rxBufIdx,
    output logic rxBufFull,
    output logic [15:0] rxPayload67,
    output logic [4:0] matchingFilterIndex
);
    logic [31:0] full = 32'h0;
    initial {rxStore, rxBufIdx, rxBufFull, rxPayload67, matchingFilterIndex} = 0;
    // Store held n edges; idle lines flip so stale data is never reused
    task automatic store(input logic [4:0] i, input logic [15:0] p, input int n);
        @(posedge clk_sys);
        {rxStore, rxBufIdx, rxBufFull, rxPayload67} <= {1'b1, i, full[i], p};
        matchingFilterIndex <= ~i;
        full[i] = 1'b1;
        repeat (n) @(posedge clk_sys);
        {rxStore, rxBufIdx, rxPayload67} <= {1'b0, ~i, ~p};
        matchingFilterIndex <= i;
    endtask
endmodule // rx_path_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the overrun flags and buffer tail words
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_ovf_defines.vh"
module tb_top;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, irq, rxStore, rxBufFull;
    logic [4:0] rxBufIdx, matchingFilterIndex;
    logic [15:0] rxPayload67;
    int n_fail = 0, comparisons = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    can_rx_overflow_and_buffer_tail DUT (.clk_sys, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxStore,
        .rxBufIdx, .rxBufFull, .rxPayload67, .matchingFilterIndex, .irq);
    rx_path_model rxm (.clk_sys, .rxStore, .rxBufIdx, .rxBufFull,
        .rxPayload67, .matchingFilterIndex);
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    task automatic test_done;
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog; the sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 0;
        rdc(`OFS_OVF_LOW, 0);
        rdc(`OFS_OVF_HIGH, 0);
        apb(1, `OFS_IRQ_MASK, 1);
        // First store fills the buffer, the second one overruns it
        for (int i = 3; i < 21; i += 17) begin
            rxm.store(i[4:0], 16'hb700 + i, 1);
            rxm.store(i[4:0], 16'hffff, 1);
        end
        rdc(`OFS_OVF_LOW, 32'h8);
        rdc(`OFS_OVF_HIGH, 32'h10);
        chk(irq, 1);
        apb(1, `OFS_BUF_SEL, 20);
        rdc(`OFS_BUF_WORD6, 32'hb714);
        rdc(`OFS_BUF_WORD7, 32'h0b00);
        apb(1, `OFS_OVF_LOW, 32'hffff);
        rdc(`OFS_OVF_LOW, 32'h8);
        apb(1, `OFS_BUF_WORD7, 32'hffff);
        rdc(`OFS_BUF_WORD7, 32'h1f00);
        apb(1, `OFS_BUF_WORD6, 32'h1234);
        rdc(`OFS_BUF_WORD6, 32'h1234);
        // One-cycle overrun lands on the very edge of the clearing write
        fork
            begin
                @(posedge clk_sys);
                rxm.store(20, 16'h0, 1);
            end
            apb(1, `OFS_OVF_HIGH, 0);
        join
        rdc(`OFS_OVF_HIGH, 32'h10);
        apb(1, `OFS_OVF_LOW, 0);
        rdc(`OFS_OVF_LOW, 0);
        apb(1, `OFS_IRQ_STATUS, 3);
        apb(1, `OFS_IRQ_MASK, 0);
        rxm.store(3, 16'h0, 1);
        rdc(`OFS_IRQ_STATUS, 1);
        chk(irq, 0);
        apb(0, 12'h01c, 0);
        chk({rd[31:1], err}, 1);
        test_done;
    end
endmodule // tb_top
`default_nettype wire
